// file: mtc_cfg.svh
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef MTC_CFG_SVH
`define MTC_CFG_SVH
`define MTC_OFF_CTRL 8'h00
`define MTC_OFF_PERIOD 8'h04
`define MTC_OFF_CAPDUTY 8'h08
`define MTC_OFF_COUNT 8'h0c
`define MTC_OFF_STATUS 8'h10
`define MTC_OFF_CMD 8'h14
`define MTC_CTRL_MODE_LSB 0
`define MTC_CTRL_START_LSB 4
`define MTC_CTRL_ACAP_BIT 6
`define MTC_CTRL_CAPTURE_EDGE_MODE_BIT 7
`define MTC_CTRL_SHOT_BIT 8
`define MTC_CTRL_TFF_BIT 9
`define MTC_CTRL_DIV_LSB 16
`define MTC_CTRL_RESET 32'h0000_0000
`define MTC_PERIOD_RESET 16'hffff
`define MTC_CAPDUTY_RESET 16'h0000
`define MTC_DIV_RESET 8'h03
`define MTC_CLK_MHZ 50
`define MTC_MACHINE_NS 80
`define MTC_MIN_PULSE_CYC ((2 * `MTC_MACHINE_NS * `MTC_CLK_MHZ + 999) / 1000)
`endif

// file: mtc_pkg.sv
// Types shared by the timer modules
package mtc_pkg;
    typedef enum logic [2:0] {
        MTC_MODE_TIMER = 3'b000,
        MTC_MODE_EXTTRIG = 3'b001,
        MTC_MODE_EVENT = 3'b010,
        MTC_MODE_WINDOW = 3'b011,
        MTC_MODE_PULSEW = 3'b100,
        MTC_MODE_PPG = 3'b101
    } mtc_mode_t;
    typedef enum logic [1:0] {
        MTC_START_STOP = 2'b00,
        MTC_START_RUN = 2'b01,
        MTC_START_RISE = 2'b10,
        MTC_START_FALL = 2'b11
    } mtc_start_t;
endpackage

// file: mtc_pin_if.sv
// Interface carrying the conditioned input pin events between modules
`timescale 1ns/1ns
`default_nettype none
interface mtc_pin_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// file: mtc_pin_sync.sv
// Three-stage synchroniser and edge detector for the timer input pin
`timescale 1ns/1ns
`default_nettype none
module mtc_pin_sync (
    input wire logic CLK, // System clock
    input wire logic RST_B, // Async reset, active low
    input wire logic pin_in, // Raw pin
    mtc_pin_if.src ev // Conditioned level and edges
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign ev.level = s3_q;
    assign ev.rise = s2_q & ~s3_q;
    assign ev.fall = ~s2_q & s3_q;
endmodule
`default_nettype wire

// file: mtc_timer.sv
// Multimode 16-bit timer with capture and pulse output behind AHB-Lite
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "mtc_cfg.svh"
// Behaviour
// - Event mode counts selected pin edges; period match interrupts and clears.
// - Event mode match is checked only on the opposite pin edge.
// - Auto-capture copies counter each tick; wait one tick before reading.
// - Window mode counts ticks while window level active; match clears.
// - Start field picks window polarity, high or low.
// - Pulse-width starts at trigger edge, captures and interrupts at opposite.
// - Single-edge capture sets counter to 1; double-edge keeps and captures again.
// - Single-edge holds counter at 1 after capture until next trigger.
// - Pulse output starts on selected edge or software command.
// - Duty match toggles output and interrupts; period match likewise.
// - Period match: one-shot clears start field; continuous clears counter.
// - Start field at 00 freezes the pulse output pin level.
// - Flip-flop resets 0, loads initial level at start, pin is inverse.
// - Capture/duty writes ignored outside pulse-output mode.
// - Timer then pulse mode with initial level reinitialises flip-flop.
// - Low-power stop entry clears start field to 00.
module mtc_timer #(
    parameter int CW = 16
) (
    input wire logic CLK, // 50 MHz system clock
    input wire logic RST_B, // Async reset, active low
    input wire logic HSEL, // Slave select
    input wire logic [7:0] HADDR, // Byte address
    input wire logic [1:0] HTRANS, // Transfer type
    input wire logic HWRITE, // Write when high
    input wire logic [2:0] HSIZE, // Transfer size
    input wire logic [31:0] HWDATA, // Write data
    input wire logic HREADY, // Bus ready in
    output logic [31:0] HRDATA, // Read data
    output logic HREADYOUT, // Slave ready
    output logic HRESP, // Always OKAY
    input wire logic TIMER_INPUT_PIN, // Event, window or trigger input
    input wire logic STOP_ENTRY, // Low-power stop entry pulse
    output logic PULSE_OUTPUT_PIN, // Pulse output
    output logic MATCH_INTERRUPT // One-cycle match/capture pulse
);
    mtc_pin_if pin ();
    mtc_pin_sync u_sync (
        .CLK(CLK),
        .RST_B(RST_B),
        .pin_in(TIMER_INPUT_PIN),
        .ev(pin)
    );

    logic [31:0] ctrl_q;
    logic [CW-1:0] period_q;
    logic [CW-1:0] capduty_q;
    logic [CW-1:0] count_q;
    logic [7:0] div_cnt_q;
    logic tick;
    logic tff_q;
    logic run_q;
    logic hold_q;
    logic first_q;
    logic sticky_q;
    logic ph_wr_q;
    logic ph_rd_q;
    logic [7:0] ph_addr_q;
    logic irq_d;
    logic wr_ctrl;
    logic prev_ppg_q;
    mtc_pkg::mtc_mode_t mode;
    mtc_pkg::mtc_start_t start;
    logic acap;
    logic capture_edge_mode;
    logic shot;
    logic win_act;
    logic cnt_edge;
    logic opp_edge;
    logic ppg_go;
    logic [CW-1:0] wdata16;

    assign mode = mtc_pkg::mtc_mode_t'(ctrl_q[`MTC_CTRL_MODE_LSB +: 3]);
    assign start = mtc_pkg::mtc_start_t'(ctrl_q[`MTC_CTRL_START_LSB +: 2]);
    assign acap = ctrl_q[`MTC_CTRL_ACAP_BIT];
    assign capture_edge_mode = ctrl_q[`MTC_CTRL_CAPTURE_EDGE_MODE_BIT];
    assign shot = ctrl_q[`MTC_CTRL_SHOT_BIT];
    assign wdata16 = HWDATA[CW-1:0];

    // Bus address phase capture
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ph_wr_q <= 1'b0;
            ph_rd_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end
        else if (HREADY)
        begin
            ph_wr_q <= HSEL & HTRANS[1] & HWRITE;
            ph_rd_q <= HSEL & HTRANS[1] & ~HWRITE;
            ph_addr_q <= HADDR;
        end
    end
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign wr_ctrl = ph_wr_q && ph_addr_q == `MTC_OFF_CTRL;

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            HRDATA <= 32'h0000_0000;
        else if (HREADY && HSEL && HTRANS[1] && !HWRITE)
        begin
            unique case (HADDR)
                `MTC_OFF_CTRL: HRDATA <= ctrl_q;
                `MTC_OFF_PERIOD: HRDATA <= {16'h0000, period_q};
                `MTC_OFF_CAPDUTY: HRDATA <= {16'h0000, capduty_q};
                `MTC_OFF_COUNT: HRDATA <= {16'h0000, count_q};
                `MTC_OFF_STATUS: HRDATA <= {28'h0000000, first_q, sticky_q, run_q, tff_q};
                default: HRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Source-clock prescaler: one tick every div+1 system clocks
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            div_cnt_q <= 8'h00;
        else if (tick)
            div_cnt_q <= 8'h00;
        else
            div_cnt_q <= div_cnt_q + 8'h01;
    end
    assign tick = div_cnt_q >= ctrl_q[`MTC_CTRL_DIV_LSB +: 8];

    assign win_act = (start == mtc_pkg::MTC_START_FALL) ? ~pin.level : pin.level;
    assign cnt_edge = (start == mtc_pkg::MTC_START_FALL) ? pin.fall : pin.rise;
    assign opp_edge = (start == mtc_pkg::MTC_START_FALL) ? pin.rise : pin.fall;
    assign ppg_go = (start == mtc_pkg::MTC_START_RUN) ? 1'b1 : cnt_edge;

    // Control register, with hardware stop of the start field
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            ctrl_q <= `MTC_CTRL_RESET | (32'(`MTC_DIV_RESET) << `MTC_CTRL_DIV_LSB);
        else if (STOP_ENTRY)
            ctrl_q[`MTC_CTRL_START_LSB +: 2] <= 2'b00;
        else if (mode == mtc_pkg::MTC_MODE_PPG && run_q && tick && count_q == period_q && shot)
            ctrl_q[`MTC_CTRL_START_LSB +: 2] <= 2'b00;
        else if (wr_ctrl)
            ctrl_q <= HWDATA;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            period_q <= `MTC_PERIOD_RESET;
        else if (ph_wr_q && ph_addr_q == `MTC_OFF_PERIOD)
            period_q <= wdata16;
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            prev_ppg_q <= 1'b0;
        else
            prev_ppg_q <= (mode == mtc_pkg::MTC_MODE_PPG);
    end

    // Counter, run state and capture
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            count_q <= '0;
            capduty_q <= `MTC_CAPDUTY_RESET;
            run_q <= 1'b0;
            hold_q <= 1'b0;
            first_q <= 1'b0;
            irq_d <= 1'b0;
        end
        else
        begin
            irq_d <= 1'b0;
            if (ph_wr_q && ph_addr_q == `MTC_OFF_CAPDUTY && mode == mtc_pkg::MTC_MODE_PPG)
                capduty_q <= wdata16;
            if (start == mtc_pkg::MTC_START_STOP)
            begin
                run_q <= 1'b0;
                hold_q <= 1'b0;
                first_q <= 1'b1;
                if (mode != mtc_pkg::MTC_MODE_PPG)
                    count_q <= '0;
            end
            else
            begin
                unique case (mode)
                    mtc_pkg::MTC_MODE_EVENT:
                    begin
                        if (cnt_edge)
                            count_q <= count_q + 1'b1;
                        else if (opp_edge && count_q == period_q)
                        begin
                            irq_d <= 1'b1;
                            count_q <= '0;
                        end
                        if (acap && tick)
                            capduty_q <= count_q;
                    end
                    mtc_pkg::MTC_MODE_WINDOW:
                    begin
                        if (tick && win_act)
                        begin
                            if (count_q == period_q)
                            begin
                                irq_d <= 1'b1;
                                count_q <= '0;
                            end
                            else
                                count_q <= count_q + 1'b1;
                        end
                        if (acap && tick)
                            capduty_q <= count_q;
                    end
                    mtc_pkg::MTC_MODE_PULSEW:
                    begin
                        if (cnt_edge)
                        begin
                            run_q <= 1'b1;
                            hold_q <= 1'b0;
                            if (!capture_edge_mode && run_q)
                            begin
                                capduty_q <= count_q;
                                irq_d <= 1'b1;
                                if (tick)
                                    count_q <= count_q + 1'b1;
                            end
                        end
                        else if (opp_edge && run_q)
                        begin
                            capduty_q <= count_q;
                            irq_d <= 1'b1;
                            first_q <= 1'b0;
                            if (capture_edge_mode)
                            begin
                                count_q <= {{(CW-1){1'b0}}, 1'b1};
                                hold_q <= 1'b1;
                                run_q <= 1'b0;
                            end
                            else if (tick)
                                count_q <= count_q + 1'b1;
                        end
                        else if (tick && run_q && !hold_q)
                            count_q <= count_q + 1'b1;
                    end
                    mtc_pkg::MTC_MODE_PPG:
                    begin
                        if (!run_q)
                        begin
                            if (ppg_go)
                            begin
                                run_q <= 1'b1;
                                count_q <= '0;
                            end
                        end
                        else if (tick)
                        begin
                            if (count_q == period_q)
                            begin
                                irq_d <= 1'b1;
                                count_q <= '0;
                            end
                            else
                            begin
                                if (count_q == capduty_q)
                                    irq_d <= 1'b1;
                                count_q <= count_q + 1'b1;
                            end
                        end
                    end
                    default:
                    begin
                        if (tick)
                        begin
                            if (count_q == period_q)
                            begin
                                irq_d <= 1'b1;
                                count_q <= '0;
                            end
                            else
                                count_q <= count_q + 1'b1;
                        end
                        if (acap && tick)
                            capduty_q <= count_q;
                    end
                endcase
            end
        end
    end

    // Sticky event flag, cleared by write of 1; a new event wins
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            sticky_q <= 1'b0;
        else if (irq_d)
            sticky_q <= 1'b1;
        else if (ph_wr_q && ph_addr_q == `MTC_OFF_STATUS && HWDATA[2])
            sticky_q <= 1'b0;
    end

    // Output flip-flop
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            tff_q <= 1'b0;
        else if (mode == mtc_pkg::MTC_MODE_PPG && !prev_ppg_q)
            tff_q <= ctrl_q[`MTC_CTRL_TFF_BIT];
        else if (wr_ctrl && HWDATA[`MTC_CTRL_MODE_LSB +: 3] == 3'b101
                 && start == mtc_pkg::MTC_START_STOP && !run_q)
            tff_q <= HWDATA[`MTC_CTRL_TFF_BIT];
        else if (mode == mtc_pkg::MTC_MODE_PPG && run_q && tick
                 && start != mtc_pkg::MTC_START_STOP
                 && (count_q == period_q || count_q == capduty_q))
            tff_q <= ~tff_q;
    end

    assign PULSE_OUTPUT_PIN = ~tff_q;
    assign MATCH_INTERRUPT = irq_d;
endmodule
`default_nettype wire

// file: mtc_pulse_src.sv
// Behavioural model of the external pulse source on the timer input pin
`timescale 1ns/1ns
`default_nettype none
module mtc_pulse_src (
    input wire logic CLK, // System clock
    output var logic PIN // Timer input pin
);
    initial
    begin
        PIN = 1'b0;
    end

    // Never shorter than eight clocks per level
    task automatic hold(input logic v, input int n);
        PIN <= v;
        repeat ((n < 8) ? 8 : n) @(posedge CLK);
    endtask

    task automatic pulses(input int k, input int hi, input int lo);
        repeat (k)
        begin
            hold(1'b1, hi);
            hold(1'b0, lo);
        end
    endtask
endmodule
`default_nettype wire

// file: mtc_timer_chk.sv
// Port-level assertions for the multimode timer
`timescale 1ns/1ns
`default_nettype none
module mtc_timer_chk #(
    parameter int CW = 16
) (
    input wire logic CLK, // Clock
    input wire logic RST_B, // Reset, active low
    input wire logic HSEL, // Select
    input wire logic [7:0] HADDR, // Address
    input wire logic [1:0] HTRANS, // Transfer type
    input wire logic HWRITE, // Write
    input wire logic [31:0] HWDATA, // Write data
    input wire logic HREADY, // Ready in
    input wire logic HREADYOUT, // Ready out
    input wire logic HRESP, // Response
    input wire logic TIMER_INPUT_PIN, // Input pin
    input wire logic STOP_ENTRY, // Stop entry
    input wire logic PULSE_OUTPUT_PIN, // Pulse pin
    input wire logic MATCH_INTERRUPT // Interrupt
);
    logic wr_pend_q;
    logic [9:0] ctrl_q;
    logic pin_q;
    logic [3:0] since_chg_q;
    logic [3:0] since_wr_q;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    // Shadow of the control word
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            wr_pend_q <= 1'b0;
            ctrl_q <= 10'h000;
        end
        else
        begin
            wr_pend_q <= HSEL && HTRANS[1] && HREADY && HWRITE && HADDR == 8'h00;
            if (wr_pend_q)
                ctrl_q <= HWDATA[9:0];
        end
    end

    // Cycles since the pin or the control word last changed
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            pin_q <= 1'b0;
            since_chg_q <= 4'hf;
            since_wr_q <= 4'hf;
        end
        else
        begin
            pin_q <= TIMER_INPUT_PIN;
            since_chg_q <= (TIMER_INPUT_PIN != pin_q) ? 4'h0 : since_chg_q + (since_chg_q != 4'hf);
            since_wr_q <= wr_pend_q ? 4'h0 : since_wr_q + (since_wr_q != 4'hf);
        end
    end

    a_rst_pin_high: assert property ($rose(RST_B) |-> PULSE_OUTPUT_PIN && !MATCH_INTERRUPT)
        else $error("pulse pin or interrupt wrong after reset");
    a_int_one_cycle: assert property (MATCH_INTERRUPT |=> !MATCH_INTERRUPT)
        else $error("interrupt longer than one cycle");
    a_event_opp_edge: assert property (ctrl_q[2:0] == mtc_pkg::MTC_MODE_EVENT && MATCH_INTERRUPT
        |-> since_chg_q inside {[2:7]} && TIMER_INPUT_PIN == (ctrl_q[5:4] == 2'b11))
        else $error("event match not on opposite edge");
    a_pw_edge_only: assert property (ctrl_q[2:0] == mtc_pkg::MTC_MODE_PULSEW && MATCH_INTERRUPT
        |-> since_chg_q inside {[2:7]})
        else $error("capture without a pin edge");
    a_window_level: assert property (ctrl_q[2:0] == mtc_pkg::MTC_MODE_WINDOW && MATCH_INTERRUPT
        && since_chg_q == 4'hf |-> TIMER_INPUT_PIN == (ctrl_q[5:4] != 2'b11))
        else $error("window match outside active level");
    a_ppg_pin_toggle: assert property (ctrl_q[2:0] == mtc_pkg::MTC_MODE_PPG && ctrl_q[5:4] != 2'b00
        && since_wr_q > 4'h4 && $changed(PULSE_OUTPUT_PIN)
        |-> (##[0:1] MATCH_INTERRUPT) or $past(MATCH_INTERRUPT) || $past(MATCH_INTERRUPT, 2))
        else $error("pulse toggle without interrupt");
    a_stop_quiet: assert property (STOP_ENTRY |-> ##2 !MATCH_INTERRUPT [*8])
        else $error("interrupt after stop entry");
    a_stop_pin_hold: assert property (STOP_ENTRY |-> ##2 $stable(PULSE_OUTPUT_PIN) [*8])
        else $error("pulse pin moved after stop");
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus not ready or error response");
endmodule
`default_nettype wire

// file: mtc_tb.sv
// Self-checking testbench for the multimode timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected %0t: %h vs %h", $time, a, e); end end
module testbench;
    localparam logic [31:0] DIV = 32'h0003_0000;
    logic CLK, RST_B, HSEL, HWRITE, HREADYOUT, HRESP, STOP_ENTRY;
    logic TIMER_INPUT_PIN, PULSE_OUTPUT_PIN, MATCH_INTERRUPT;
    logic [7:0] HADDR;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [31:0] HWDATA, HRDATA, r, c1, c2;
    logic [31:0] c [3];
    logic p;
    int num_errors = 0;
    int checks_done = 0;
    int ints = 0;
    int n;

    mtc_timer #(.CW(16)) dut (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TIMER_INPUT_PIN(TIMER_INPUT_PIN),
        .STOP_ENTRY(STOP_ENTRY), .PULSE_OUTPUT_PIN(PULSE_OUTPUT_PIN),
        .MATCH_INTERRUPT(MATCH_INTERRUPT));
    mtc_pulse_src src (.CLK(CLK), .PIN(TIMER_INPUT_PIN));

    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    always @(posedge CLK)
        if (MATCH_INTERRUPT === 1'b1)
            ints <= ints + 1;

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HWRITE <= w;
        HADDR <= a;
        HSIZE <= 3'b010;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        q = HRDATA;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    task automatic t_regs();
        rd(8'h04, r);
        `CHK(r, 32'h0000ffff)
        rd(8'h1c, r);
        `CHK(r, 32'h0)
        wr(8'h08, 32'h1234);
        rd(8'h08, r);
        `CHK(r, 32'h0)
    endtask

    task automatic t_event();
        wr(8'h04, 32'h3);
        wr(8'h00, DIV | 32'h22);
        n = ints;
        src.pulses(2, 10, 10);
        src.hold(1'b1, 30);
        `CHK(ints - n, 0)
        src.hold(1'b0, 12);
        `CHK(ints - n, 1)
        rd(8'h0c, r);
        `CHK(r, 32'h0)
        rd(8'h10, r);
        `CHK(r[2], 1'b1)
        wr(8'h10, 32'h4);
        rd(8'h10, r);
        `CHK(r[2], 1'b0)
    endtask

    task automatic t_window();
        wr(8'h00, DIV);
        src.hold(1'b1, 8);
        wr(8'h04, 32'h5);
        wr(8'h00, DIV | 32'h33);
        n = ints;
        src.hold(1'b1, 100);
        `CHK(ints - n, 0)
        src.hold(1'b0, 28);
        src.hold(1'b1, 12);
        `CHK(ints - n, 1)
    endtask

    task automatic t_acap();
        wr(8'h00, DIV);
        wr(8'h04, 32'h100);
        wr(8'h00, DIV | 32'h50);
        repeat (40) @(posedge CLK);
        rd(8'h08, c1);
        rd(8'h0c, c2);
        `CHK((c2 - c1) inside {[1:2]}, 1'b1)
        wr(8'h00, DIV);
    endtask

    task automatic t_pwidth();
        wr(8'h00, DIV);
        src.hold(1'b0, 8);
        wr(8'h00, DIV | 32'ha4);
        n = ints;
        for (int i = 0; i < 3; i++)
        begin
            fork
                src.pulses(1, 40, 40);
                begin
                    repeat (50) @(posedge CLK);
                    rd(8'h08, c[i]);
                end
            join
        end
        `CHK(ints - n, 3)
        `CHK(c[1] - c[0], 32'd1)
        `CHK(c[2], c[1])
        wr(8'h00, DIV);
        wr(8'h00, DIV | 32'h24);
        fork
            src.pulses(1, 40, 40);
            begin
                repeat (50) @(posedge CLK);
                rd(8'h08, c1);
            end
        join
        fork
            src.hold(1'b1, 20);
            begin
                repeat (10) @(posedge CLK);
                rd(8'h08, c2);
            end
        join
        `CHK(c2 - c1, 32'd10)
    endtask

    task automatic t_ppg();
        // Pin driven directly; no port latch in this block
        wr(8'h00, DIV);
        wr(8'h00, DIV | 32'h5);
        repeat (4) @(posedge CLK);
        `CHK(PULSE_OUTPUT_PIN, 1'b1)
        wr(8'h04, 32'h8);
        wr(8'h08, 32'h3);
        rd(8'h08, r);
        `CHK(r, 32'h3)
        n = ints;
        wr(8'h00, DIV | 32'h115);
        repeat (24) @(posedge CLK);
        `CHK(PULSE_OUTPUT_PIN, 1'b0)
        repeat (40) @(posedge CLK);
        @(negedge CLK);
        `CHK(ints - n, 2)
        `CHK(PULSE_OUTPUT_PIN, 1'b1)
        @(posedge CLK);
        rd(8'h00, r);
        `CHK(r[5:4], 2'b00)
        n = ints;
        wr(8'h00, DIV | 32'h015);
        repeat (320) @(posedge CLK);
        STOP_ENTRY <= 1'b1;
        @(posedge CLK);
        STOP_ENTRY <= 1'b0;
        repeat (3) @(negedge CLK);
        p = PULSE_OUTPUT_PIN;
        `CHK(ints - n, 17)
        repeat (20) @(negedge CLK);
        `CHK(PULSE_OUTPUT_PIN, p)
        @(posedge CLK);
        rd(8'h00, r);
        `CHK(r[5:4], 2'b00)
        wr(8'h00, DIV);
        wr(8'h00, DIV | 32'h205);
        repeat (4) @(posedge CLK);
        `CHK(PULSE_OUTPUT_PIN, 1'b0)
        src.hold(1'b0, 8);
        wr(8'h00, DIV | 32'h325);
        n = ints;
        src.hold(1'b0, 20);
        `CHK(ints - n, 0)
        src.hold(1'b1, 60);
        `CHK(ints - n, 2)
        `CHK(PULSE_OUTPUT_PIN, 1'b0)
    endtask

    task automatic stop_test();
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        RST_B = 1'b0;
        HSEL = 1'b0;
        HADDR = 8'h00;
        HTRANS = 2'b00;
        HWRITE = 1'b0;
        HSIZE = 3'b010;
        HWDATA = 32'h0;
        STOP_ENTRY = 1'b0;
        repeat (10) @(posedge CLK);
        RST_B <= 1'b1;
        @(negedge CLK);
        `CHK(PULSE_OUTPUT_PIN, 1'b1)
        @(posedge CLK);
        t_regs();
        t_event();
        t_window();
        t_acap();
        t_pwidth();
        t_ppg();
        stop_test();
    end

    initial
    begin
        repeat (20000) @(posedge CLK);
        num_errors++;
        stop_test();
    end
endmodule
bind mtc_timer mtc_timer_chk #(.CW(CW)) chk (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TIMER_INPUT_PIN(TIMER_INPUT_PIN),
    .STOP_ENTRY(STOP_ENTRY), .PULSE_OUTPUT_PIN(PULSE_OUTPUT_PIN),
    .MATCH_INTERRUPT(MATCH_INTERRUPT));
`default_nettype wire
